// ==== rxfr_framer_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "rxfr_defs.vh"
// ----------------------------------------------------------------
// Receive framer and decoder select with AXI4-Lite registers
// ----------------------------------------------------------------
module rxfr_framer_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        rx_bit,               // Serial bit, oldest first
  input  wire        rx_bit_valid,         // One bit per strobe
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg  [9:0]  rx_char_out,          // Output register
  output reg         rx_char_special,      // Special code flag
  output reg         rx_char_valid,        // One-cycle pulse per char
  output reg         receive_clock_output  // Character clock
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Framing character test on the ten newest bits
  function match_frame;
    input [9:0] w;
    input       fullk;
    begin
      if (fullk)
        match_frame = (w == `RXFR_K285_P) || (w == `RXFR_K285_N);
      else
        match_frame = (w[9:3] == `RXFR_COMMA_P) || (w[9:3] == `RXFR_COMMA_N);
    end
  endfunction

  // Boundary offset from the phase at which a match ended
  function [3:0] phase_to_off;
    input [3:0] ph;
    begin
      phase_to_off = `RXFR_LAST_PHASE - ph;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [31:0] ctrl;          // Control register
  reg  [19:0] shreg;         // Two characters of history
  reg  [3:0]  phase;         // Bit position within character
  reg  [3:0]  offset;        // Applied boundary offset
  reg  [3:0]  cand_phase;    // Phase of last candidate match
  reg         cand_seen;     // A candidate is pending
  reg  [5:0]  span;          // Bits since last candidate
  reg  [2:0]  run;           // Adjacent matches on one boundary
  reg  [7:0]  realign_cnt;   // Realignments since reset
  reg         dual_tog;      // Dual-character rate divider
  reg         ref_tog;       // Reference-derived clock
  reg  [4:0]  settle;        // Counts cycles after reset release
  reg         cfg_err;       // Bypass with wrong clock select
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire [1:0]  dec_mode  = ctrl[`RXFR_F_DEC];
  wire [1:0]  rf_mode   = ctrl[`RXFR_F_RFM];
  wire [1:0]  ck_sel    = ctrl[`RXFR_F_CKSEL];
  wire        bonded    = (ctrl[`RXFR_F_BOND] != `RXFR_BOND_NONE);
  wire [19:0] next_sh   = {shreg[18:0], rx_bit};
  wire        hit       = match_frame(next_sh[9:0], ctrl[`RXFR_B_FULLK]);
  wire [19:0] aligned   = next_sh >> offset;
  wire        char_end  = (phase == `RXFR_LAST_PHASE);
  // Bonded channels cannot stretch their clock, so low-latency
  // falls back to the pair framer there
  wire        low_lat   = (rf_mode == `RXFR_LVL_LOW) && !bonded;
  wire [9:0]  dec_char;
  wire        dec_special;

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  rxfr_decoder u_dec (
    .raw_char            (aligned[9:0]),
    .decoder_mode_select (dec_mode),
    .dec_char            (dec_char),
    .dec_special         (dec_special)
  );

  // ----------------------------------------------------------------
  // Bit phase, framing and output register
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg           <= 20'h0;
      phase           <= 4'h0;
      offset          <= 4'h0;
      cand_phase      <= 4'h0;
      cand_seen       <= 1'b0;
      span            <= 6'h0;
      run             <= 3'h0;
      realign_cnt     <= 8'h0;
      rx_char_out     <= 10'h0;
      rx_char_special <= 1'b0;
      rx_char_valid   <= 1'b0;
    end else begin
      rx_char_valid <= 1'b0;
      if (rx_bit_valid) begin
        shreg <= next_sh;
        // Default phase advance and character delivery
        if (char_end) begin
          phase           <= 4'h0;
          rx_char_out     <= dec_char;
          rx_char_special <= dec_special;
          rx_char_valid   <= 1'b1;
        end else begin
          phase <= phase + 4'h1;
        end
        if (span != `RXFR_PAIR_SPAN)
          span <= span + 6'h1;
        if (hit && low_lat) begin
          // Restart the character here: clock is stretched
          phase           <= 4'h0;
          offset          <= 4'h0;
          rx_char_out     <= dec_char;
          rx_char_special <= dec_special;
          rx_char_valid   <= 1'b1;
          realign_cnt     <= realign_cnt + 8'h1;
        end else if (hit && rf_mode == `RXFR_LVL_HIGH) begin
          // Four adjacent characters on one boundary
          if (cand_seen && cand_phase == phase && span == `RXFR_ADJ_SPAN) begin
            if (run == `RXFR_ADJ_COUNT - 3'h1) begin
              offset      <= phase_to_off(phase);
              realign_cnt <= realign_cnt + 8'h1;
              run         <= 3'h0;
              cand_seen   <= 1'b0;
            end else begin
              run <= run + 3'h1;
            end
          end else begin
            run       <= 3'h1;
            cand_seen <= 1'b1;
          end
          cand_phase <= phase;
          span       <= 6'h0;
        end else if (hit) begin
          // Pair on one boundary within the span
          if (cand_seen && cand_phase == phase && span < `RXFR_PAIR_SPAN) begin
            offset      <= phase_to_off(phase);
            realign_cnt <= realign_cnt + 8'h1;
            cand_seen   <= 1'b0;
          end else begin
            cand_seen <= 1'b1;
          end
          cand_phase <= phase;
          span       <= 6'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Character clock output
  // ----------------------------------------------------------------
  // Recovered clock comes from the bit phase; reference mode uses
  // a divided system clock since the link clock is not present
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dual_tog             <= 1'b0;
      ref_tog              <= 1'b0;
      receive_clock_output <= 1'b0;
    end else begin
      ref_tog <= ~ref_tog;
      if (rx_bit_valid && char_end)
        dual_tog <= ~dual_tog;
      if (ck_sel == `RXFR_LVL_LOW)
        receive_clock_output <= ref_tog;
      else if (ctrl[`RXFR_B_RATE])
        receive_clock_output <= ~dual_tog;
      else
        receive_clock_output <= (phase < `RXFR_HALF_PHASE);
    end
  end

  // ----------------------------------------------------------------
  // Reset settle counter and configuration check
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle  <= 5'h0;
      cfg_err <= 1'b0;
    end else begin
      if (settle != `RXFR_RST_CYCLES)
        settle <= settle + 5'h1;
      // The far side must keep the clock select mid in bypass
      cfg_err <= (dec_mode == `RXFR_LVL_LOW) && (ck_sel != `RXFR_LVL_MID);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are caught in either order; one response each
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RXFR_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      ctrl          <= `RXFR_CTRL_RESET;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `RXFR_ADDR_CTRL) begin
          s_axi_bresp <= `RXFR_RESP_OKAY;
          // Modes are meant to change only while the path is reset; the write is taken whenever it arrives
          if (w_strb[0])
            ctrl[7:0] <= w_data[7:0];
          if (w_strb[1])
            ctrl[9:8] <= w_data[9:8];
        end else if (aw_addr == `RXFR_ADDR_STATUS || aw_addr == `RXFR_ADDR_DATA) begin
          s_axi_bresp <= `RXFR_RESP_OKAY;                  // Read-only, write ignored
        end else begin
          s_axi_bresp <= `RXFR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RXFR_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RXFR_RESP_OKAY;
        case (s_axi_araddr)
          `RXFR_ADDR_CTRL: begin
            s_axi_rdata <= {22'h0, ctrl[9:0]};
          end
          `RXFR_ADDR_STATUS: begin
            s_axi_rdata <= {14'h0, cfg_err, (settle == `RXFR_RST_CYCLES),
                            realign_cnt, 4'h0, offset};
          end
          `RXFR_ADDR_DATA: begin
            s_axi_rdata <= {21'h0, rx_char_special, rx_char_out};
          end
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RXFR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rxfr_framer_top
`default_nettype wire

// ==== rxfr_defs.vh ====
// Notes on behaviour
// - Decoder low: raw 10-bit character passes unchanged.
// - Decoder mid: primary special-code table used.
// - Decoder high: alternate special-code table used.
// - Framing follows bonding mode and character type.
// - Reframe low: realign on every framing character when not bonded; bonded falls back to reframe mid.
// - Low-latency realign stretches the character clock.
// - Reframe mid: two matches, same boundary, 50 bits.
// - Reframe high: four adjacent matches, same boundary.
// - Multi-byte framers keep character clock phase.
// - Clock select mid: output follows recovered clock.
// - Reset clears state; deterministic within 16 cycles.
`ifndef RXFR_DEFS_VH
`define RXFR_DEFS_VH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define RXFR_ADDR_CTRL    4'h0
`define RXFR_ADDR_STATUS  4'h4
`define RXFR_ADDR_DATA    4'h8
`define RXFR_CTRL_RESET   32'h0000_0014
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RXFR_F_DEC        1:0
`define RXFR_F_RFM        3:2
`define RXFR_F_CKSEL      5:4
`define RXFR_B_RATE       6
`define RXFR_B_FULLK      7
`define RXFR_F_BOND       9:8
// ----------------------------------------------------------------
// Three-level encoding and bus answers
// ----------------------------------------------------------------
`define RXFR_LVL_LOW      2'h0
`define RXFR_LVL_MID      2'h1
`define RXFR_LVL_HIGH     2'h2
`define RXFR_BOND_NONE    2'h0
`define RXFR_RESP_OKAY    2'h0
`define RXFR_RESP_SLVERR  2'h2
// ----------------------------------------------------------------
// Character and framing constants
// ----------------------------------------------------------------
`define RXFR_CHAR_W       10
`define RXFR_LAST_PHASE   4'h9
`define RXFR_HALF_PHASE   4'h5
`define RXFR_COMMA_P      7'h1f
`define RXFR_COMMA_N      7'h60
`define RXFR_K285_P       10'h0fa
`define RXFR_K285_N       10'h305
`define RXFR_PAIR_SPAN    6'h32
`define RXFR_ADJ_COUNT    3'h4
`define RXFR_ADJ_SPAN     6'h9
`define RXFR_K28_P        6'h0f
`define RXFR_K28_N        6'h30
`define RXFR_KX7_A        4'h8
`define RXFR_KX7_B        4'h7
`define RXFR_K_LOW        5'h1c
`define RXFR_RST_CYCLES   5'h10
`endif

// ==== rxfr_decoder.v ====
`timescale 1ns/1ns
`default_nettype none
`include "rxfr_defs.vh"
// ----------------------------------------------------------------
// Character decoder: bypass, primary or alternate special table
// ----------------------------------------------------------------
module rxfr_decoder (
  input  wire [9:0] raw_char,
  input  wire [1:0] decoder_mode_select,
  output reg  [9:0] dec_char,
  output reg        dec_special
);
  reg k28;   // abcdei marks a K28 group
  reg kx7;   // fghj marks a Kx.7 group

  // Data bytes keep their 5b/6b order only; special codes are what
  // this block resolves, full data tables sit downstream.
  always @* begin
    k28         = (raw_char[9:4] == `RXFR_K28_P) || (raw_char[9:4] == `RXFR_K28_N);
    kx7         = (raw_char[3:0] == `RXFR_KX7_A) || (raw_char[3:0] == `RXFR_KX7_B);
    dec_char    = raw_char;
    dec_special = 1'b0;
    case (decoder_mode_select)
      `RXFR_LVL_LOW: begin
        dec_char = raw_char;
      end
      `RXFR_LVL_MID: begin
        dec_special = k28;
        dec_char    = k28 ? {2'h0, raw_char[3:1], `RXFR_K_LOW}
                          : {2'h0, raw_char[3:1], raw_char[9:5]};
      end
      `RXFR_LVL_HIGH: begin
        dec_special = k28 | kx7;
        dec_char    = k28 ? {2'h0, raw_char[3:1], `RXFR_K_LOW}
                          : {2'h0, raw_char[3:1], raw_char[9:5]};
      end
      default: begin
        dec_char = raw_char;
      end
    endcase
  end
endmodule // rxfr_decoder
`default_nettype wire

// ==== rxfr_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the framer top
// ----------------------------------------------------------------
module rxfr_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        rx_bit_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [9:0]  rx_char_out,
  input wire logic        rx_char_valid
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Ready strobes last one cycle
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
  // Answers stand until the master takes them
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // Fixed answer latency
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_wready
    && !s_axi_bvalid |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid) else $error("write late");
  // A character only follows a received bit; gaps freeze the path
  char_cause_a: assert property (rx_char_valid |-> $past(rx_bit_valid))
    else $error("char without bit");
  char_hold_a: assert property (!rx_char_valid |-> $stable(rx_char_out))
    else $error("output register moved");
  // Reset clears the outputs
  rst_quiet_a: assert property (disable iff (1'b0) !rst_b |-> !rx_char_valid && !s_axi_bvalid
    && !s_axi_rvalid && rx_char_out == 10'h000) else $error("outputs live in reset");
endmodule // rxfr_checker
bind rxfr_framer_top rxfr_checker chk_i (.clk, .rst_b, .rx_bit_valid, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_char_out,
  .rx_char_valid);
`default_nettype wire

// ==== rxfr_line_tx.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Remote serial transmitter model
// ----------------------------------------------------------------
module rxfr_line_tx (
  input  wire logic clk,
  output var  logic ln_bit,
  output var  logic ln_valid
);
  initial begin
    ln_bit   = 1'b0;
    ln_valid = 1'b0;
  end
  // Shift out n bits, first-sent bit is v[n-1]
  task automatic send(input logic [9:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      ln_bit   <= v[i];
      ln_valid <= 1'b1;
    end
  endtask
  // Line released: inverse of last bit, so no stale value looks valid
  task automatic idle();
    @(posedge clk);
    ln_valid <= 1'b0;
    ln_bit   <= ~ln_bit;
  endtask
endmodule // rxfr_line_tx
`default_nettype wire

// ==== tb_rxfr_framer_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rxfr_defs.vh"
module tb_rxfr_framer_top;
  logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0]  resp;
  logic        hit, sp_hit, kx_hit, ck_q;
  logic [1:0]  bond;       // Bonding field written by cfg
  logic [9:0]  want;
  wire         rx_bit, rx_bit_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, rx_char_special, rx_char_valid, receive_clock_output;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [9:0]  rx_char_out;
  int          errors, n_tests, n_falls;
  localparam logic [9:0] COMMA = `RXFR_K285_P;
  localparam logic [9:0] FILL  = 10'h2aa;   // No comma at any alignment
  localparam logic [9:0] KX7   = 10'h2a8;   // Kx.7 group, not a K28 group
  rxfr_framer_top DUT (.clk, .rst_b, .rx_bit, .rx_bit_valid, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_char_out, .rx_char_special, .rx_char_valid,
    .receive_clock_output);
  rxfr_line_tx tx (.clk, .ln_bit(rx_bit), .ln_valid(rx_bit_valid));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watch delivered characters and clock falls; one driver, cleared in reset
  always @(posedge clk) begin
    if (!rst_b) begin
      hit     <= 1'b0;
      sp_hit  <= 1'b0;
      kx_hit  <= 1'b0;
      ck_q    <= 1'b0;
      n_falls <= 0;
    end else begin
      ck_q <= receive_clock_output;
      if (ck_q === 1'b1 && receive_clock_output === 1'b0) n_falls <= n_falls + 1;
      if (rx_char_valid === 1'b1 && rx_char_out === want) hit <= 1'b1;
      if (rx_char_valid === 1'b1 && rx_char_special === 1'b1 && rx_char_out[4:0] === `RXFR_K_LOW)
        sp_hit <= 1'b1;
      if (rx_char_valid === 1'b1 && rx_char_special === 1'b1 && rx_char_out[4:0] !== `RXFR_K_LOW)
        kx_hit <= 1'b1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_b  <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic bd;
    bd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!bd) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        bd = 1'b1;
        r  = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    // Let an edge pass so a following call never re-drives in this step
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic dn;
    dn = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!dn) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dn = 1'b1;
        d  = s_axi_rdata;
        r  = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    // Let an edge pass so a following call never re-drives in this step
    @(posedge clk);
  endtask
  // Modes change only with the link idle; clock select kept mid
  task automatic cfg(input logic [1:0] dec, input logic [1:0] rfm);
    do_reset();
    axi_wr(`RXFR_ADDR_CTRL, {22'h0, bond, 2'h0, `RXFR_LVL_MID, rfm, dec}, resp);
    axi_rd(`RXFR_ADDR_CTRL, rd, resp);
    chk("ctrl", {22'h0, bond, 2'h0, `RXFR_LVL_MID, rfm, dec}, rd);
  endtask
  // Bypass stream: sh junk bits, n commas each with gap fillers, then want
  task automatic frame_case(input logic [1:0] rfm, input int sh, input int n, input int gap,
                            input logic exp);
    cfg(`RXFR_LVL_LOW, rfm);
    want = 10'h2b5;
    tx.send(10'h005, sh);
    repeat (n) begin
      tx.send(COMMA, 10);
      repeat (gap) tx.send(FILL, 10);
    end
    tx.send(want, 10);
    tx.send(FILL, 10);
    tx.send(FILL, 10);
    tx.idle();
    repeat (4) @(posedge clk);
    chk("aligned char", {31'h0, exp}, {31'h0, hit});
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr} = 8'h00;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h0;
    // Idle high first so the reset below is a real falling edge
    rst_b = 1'b1;
    bond = 2'h0;
    want = 10'h3ff;
    do_reset();
    axi_rd(`RXFR_ADDR_CTRL, rd, resp);
    chk("ctrl reset", `RXFR_CTRL_RESET, rd);
    repeat (16) @(posedge clk);
    axi_rd(`RXFR_ADDR_STATUS, rd, resp);
    chk("settled", 32'h1, {31'h0, rd[16]});
    axi_rd(4'hc, rd, resp);
    chk("unmapped rresp", {30'h0, `RXFR_RESP_SLVERR}, {30'h0, resp});
    axi_wr(4'hc, 32'h0, resp);
    chk("unmapped bresp", {30'h0, `RXFR_RESP_SLVERR}, {30'h0, resp});
    axi_wr(`RXFR_ADDR_CTRL, 32'h0, resp);
    axi_rd(`RXFR_ADDR_STATUS, rd, resp);
    chk("bypass clock flag", 32'h1, {31'h0, rd[17]});
    frame_case(`RXFR_LVL_MID, 0, 0, 0, 1'b1);
    frame_case(`RXFR_LVL_LOW, 3, 1, 0, 1'b1);
    frame_case(`RXFR_LVL_MID, 3, 1, 0, 1'b0);
    frame_case(`RXFR_LVL_MID, 3, 2, 3, 1'b1);
    frame_case(`RXFR_LVL_MID, 3, 2, 5, 1'b0);
    frame_case(`RXFR_LVL_HIGH, 3, 3, 0, 1'b0);
    frame_case(`RXFR_LVL_HIGH, 3, 4, 0, 1'b1);
    // Bonded: low-latency gives way to the pair framer, one comma is not enough
    bond = 2'h1;
    frame_case(`RXFR_LVL_LOW, 3, 1, 0, 1'b0);
    bond = 2'h0;
    for (int k = 1; k <= 2; k++) begin
      cfg(k[1:0], `RXFR_LVL_MID);
      tx.send(COMMA, 10);
      tx.send(KX7, 10);
      tx.send(FILL, 10);
      tx.idle();
      repeat (4) @(posedge clk);
      chk("special code", 32'h1, {31'h0, sp_hit});
      chk("alternate special", {31'h0, k == 2}, {31'h0, kx_hit});
      chk("char clock falls", 32'd3, n_falls);
    end
    print_verdict();
  end
endmodule // tb_rxfr_framer_top
`default_nettype wire
